// ==== src/gpb_pad_ctl.sv ====
`timescale 1ns/1ps
// decodes drive mode and data into pad controls for one port
module gpb_pad_ctl (
   input wire logic [23:0] dm_i,
   input wire logic [7:0] data_i,
   input wire logic [7:0] ttl_i,
   input wire logic [7:0] slow_i,
   output gpb_pkg::gpb_pad_t pad_o
);
   // decodes one pin: {oe, pull_up, pull_dn, in_en, analog}
   function automatic logic [4:0] dm_dec(input logic [2:0] dm,
                                         input logic d);
      logic [4:0] r;
      r = 5'h00;
      case (gpb_pkg::gpb_drive_t'(dm))
         gpb_pkg::GPB_DM_ANALOG: r = 5'h01;
         gpb_pkg::GPB_DM_INPUT: r = 5'h02;
         gpb_pkg::GPB_DM_WUP_SDN: r = {~d, 1'b1, 1'b0, 1'b1, 1'b0};
         gpb_pkg::GPB_DM_SUP_WDN: r = {d, 1'b0, 1'b1, 1'b1, 1'b0};
         gpb_pkg::GPB_DM_OD_LOW: r = {~d, 1'b0, 1'b0, 1'b1, 1'b0};
         gpb_pkg::GPB_DM_OD_HIGH: r = {d, 1'b0, 1'b0, 1'b1, 1'b0};
         gpb_pkg::GPB_DM_STRONG: r = 5'h12;
         gpb_pkg::GPB_DM_WEAK: r = {1'b0, d, ~d, 1'b1, 1'b0};
         default: r = 5'h01;
      endcase
      return r;
   endfunction

   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_pin
         logic [4:0] dec;
         assign dec = dm_dec(dm_i[3*g +: 3], data_i[g]); // R04
         assign pad_o.out[g] = data_i[g];
         assign pad_o.oe[g] = dec[4];
         assign pad_o.pull_up[g] = dec[3];
         assign pad_o.pull_dn[g] = dec[2];
         assign pad_o.in_en[g] = dec[1];
         assign pad_o.analog[g] = dec[0];
         assign pad_o.ttl[g] = ttl_i[g]; // R05
         assign pad_o.slow[g] = slow_i[g]; // R08
      end
   endgenerate
endmodule // gpb_pad_ctl

// ==== src/gpb_pkg.sv ====
package gpb_pkg;
   // port geometry
   localparam int unsigned PORT_W = 8;
   localparam int unsigned NUM_PORTS = 13;
   localparam int unsigned NUM_PINS = 100;
   localparam int unsigned ROUTE_W = 2;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned ROUTE_SEL_W = 1;

   // drive modes, three bits per pin
   typedef enum logic [2:0] {
      GPB_DM_ANALOG = 3'h0,
      GPB_DM_INPUT = 3'h1,
      GPB_DM_WUP_SDN = 3'h2,
      GPB_DM_SUP_WDN = 3'h3,
      GPB_DM_OD_LOW = 3'h4,
      GPB_DM_OD_HIGH = 3'h5,
      GPB_DM_STRONG = 3'h6,
      GPB_DM_WEAK = 3'h7
   } gpb_drive_t;

   // per-port register offsets; port p sits at p * PORT_STRIDE
   localparam logic [7:0] PORT_STRIDE = 8'h10;
   localparam logic [3:0] REG_OUT = 4'h0;
   localparam logic [3:0] REG_IN = 4'h1;
   localparam logic [3:0] REG_DM_LO = 4'h2;
   localparam logic [3:0] REG_DM_HI = 4'h3;
   localparam logic [3:0] REG_CFG = 4'h4;
   localparam logic [3:0] REG_ROUTE = 4'h5;
   localparam logic [3:0] REG_HOLD = 4'h6;
   localparam logic [3:0] REG_IRQ_STAT = 4'h7;
   localparam logic [3:0] REG_IRQ_CLR = 4'h8;
   localparam logic [3:0] REG_IRQ_EN = 4'h9;
   localparam logic [3:0] REG_IRQ_EDGE = 4'hA;

   // cfg register fields
   localparam int unsigned CFG_SLOW_LSB = 0;
   localparam int unsigned CFG_TTL_LSB = 8;

   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [23:0] RST_DM = 24'h000000;

   // pad-side control bundle of one port
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull_up;
      logic [7:0] pull_dn;
      logic [7:0] in_en;
      logic [7:0] ttl;
      logic [7:0] slow;
      logic [7:0] analog;
   } gpb_pad_t;
endpackage

// ==== src/gpb_port_bank.sv ====
`timescale 1ns/1ps
// Behaviour
// R01 - pins grouped in ports of eight, one bit per pin per register; drive mode here takes three bits per pin and cfg two per pin
// R02 - output data register drives pins; state register returns sampled inputs
// R03 - pin interrupts gated by enable, merged into one request per port
// R04 - eight drive modes per pin, analog through weak both ways
// R05 - per-pin input threshold choice, cmos or lvttl
// R06 - hold latch freezes pin configuration and level for deep sleep
// R07 - any reset forces every pin to analog mode, buffers off
// R08 - per-pin slow slew selection to reduce emission
// R09 - routing matrix picks peripheral signal or port data per pin
// R10 - up to one hundred pins spread over the ports
// R11 - software limits toggle rate and picks drive strength by supply; the bank has no drive-strength select, only per-pin slow slew
// R12 - inputs synchronised; flags sticky until cleared; request while enabled
module gpb_port_bank (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [gpb_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [gpb_pkg::NUM_PINS-1:0] pin_i,
   input wire logic [gpb_pkg::NUM_PINS-1:0] periph_out_i,
   input wire logic [gpb_pkg::NUM_PINS-1:0] periph_oe_i,
   input wire logic hold_req_i,
   output logic [gpb_pkg::NUM_PINS-1:0] pin_o,
   output logic [gpb_pkg::NUM_PINS-1:0] pin_oe_o,
   output logic [gpb_pkg::NUM_PINS-1:0] pull_up_o,
   output logic [gpb_pkg::NUM_PINS-1:0] pull_dn_o,
   output logic [gpb_pkg::NUM_PINS-1:0] in_en_o,
   output logic [gpb_pkg::NUM_PINS-1:0] ttl_o,
   output logic [gpb_pkg::NUM_PINS-1:0] slow_o,
   output logic [gpb_pkg::NUM_PINS-1:0] analog_o,
   output logic [gpb_pkg::NUM_PINS-1:0] periph_in_o,
   output logic [gpb_pkg::NUM_PORTS-1:0] port_irq_o
);
   localparam int unsigned NP = gpb_pkg::NUM_PORTS;
   localparam int unsigned PW = gpb_pkg::PORT_W;
   localparam int unsigned PADDED = NP * PW;

   // per-port software state
   typedef struct packed {
      logic [7:0] out;
      logic [23:0] dm;
      logic [7:0] ttl;
      logic [7:0] slow;
      logic [7:0] route;
      logic [7:0] hold_en;
      logic [7:0] stat;
      logic [7:0] en;
      logic [7:0] edge_sel;
      logic [7:0] prev;
   } gpb_port_st_t;

   typedef struct packed {
      gpb_port_st_t [NP-1:0] port;
      gpb_pkg::gpb_pad_t [NP-1:0] pad;
      logic [NP-1:0] irq;
      logic [31:0] rdata;
      logic ack;
      logic held;
   } gpb_st_t;

   gpb_st_t st_ff;
   gpb_st_t nxt_st;

   // pad the 100 pins to whole ports; spare bits stay idle
   logic [PADDED-1:0] pin_pad;
   logic [PADDED-1:0] pin_sync;
   logic [PADDED-1:0] per_out_pad;
   logic [PADDED-1:0] per_oe_pad;
   assign pin_pad = {{(PADDED-gpb_pkg::NUM_PINS){1'b0}}, pin_i}; // R10
   assign per_out_pad = {{(PADDED-gpb_pkg::NUM_PINS){1'b0}}, periph_out_i};
   assign per_oe_pad = {{(PADDED-gpb_pkg::NUM_PINS){1'b0}}, periph_oe_i};

   gpb_pkg::gpb_pad_t [NP-1:0] pad_dec;
   logic [NP-1:0][7:0] drv_data;

   genvar p;
   generate
      for (p = 0; p < NP; p++) begin : g_port
         // pins are asynchronous to clk_i
         gpb_sync u_sync (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .d_i(pin_pad[p*PW +: PW]),
            .q_o(pin_sync[p*PW +: PW])
         ); // R12
         // routed pins take peripheral data instead of port data
         assign drv_data[p] = (st_ff.port[p].route & per_out_pad[p*PW +: PW])
            | (~st_ff.port[p].route & st_ff.port[p].out); // R09
         gpb_pad_ctl u_pad (
            .dm_i(st_ff.port[p].dm),
            .data_i(drv_data[p]),
            .ttl_i(st_ff.port[p].ttl),
            .slow_i(st_ff.port[p].slow),
            .pad_o(pad_dec[p])
         );
      end
   endgenerate

   // wishbone decode helpers
   function automatic logic [3:0] port_idx(input logic [7:0] a);
      return a[7:4];
   endfunction

   function automatic logic [7:0] merge(input logic [7:0] old,
                                        input logic [7:0] wd,
                                        input logic sel0);
      return sel0 ? wd : old;
   endfunction

   logic req;
   logic [3:0] pi;
   logic [3:0] ri;
   logic hit;
   assign req = wb_cyc_i & wb_stb_i & ~st_ff.ack;
   assign pi = port_idx(wb_adr_i); // R01
   assign ri = wb_adr_i[3:0];
   assign hit = (32'(pi) < NP) && (wb_adr_i[1:0] == 2'b00);

   always_comb begin
      logic [7:0] rise;
      logic [7:0] fall;
      logic [7:0] evt;
      logic [7:0] clr;
      logic [3:0] reg_i;
      nxt_st = st_ff;
      rise = 8'h00;
      fall = 8'h00;
      evt = 8'h00;
      clr = 8'h00;
      reg_i = ri >> 2;
      nxt_st.ack = req; // one wait state, ack after one edge
      nxt_st.rdata = 32'h00000000;
      nxt_st.held = hold_req_i;

      // register access; register index = offset nibble within a port
      if (req && hit) begin
         if (wb_we_i) begin
            case ({2'b00, wb_adr_i[3:2]} | {wb_adr_i[7:4] & 4'h0})
               default: ;
            endcase
         end
      end

      for (int i = 0; i < NP; i++) begin
         // sampled levels, edge events per pin
         rise = pin_sync[i*PW +: PW] & ~st_ff.port[i].prev;
         fall = ~pin_sync[i*PW +: PW] & st_ff.port[i].prev;
         evt = (st_ff.port[i].edge_sel & fall)
            | (~st_ff.port[i].edge_sel & rise);
         nxt_st.port[i].prev = pin_sync[i*PW +: PW];
         clr = 8'h00;

         if (req && hit && (32'(pi) == i)) begin
            if (wb_we_i && wb_sel_i[0]) begin
               case ({1'b0, wb_adr_i[3:2], 1'b0} | 4'h0)
                  default: ;
               endcase
            end
         end
         // writes, decoded from the low address nibble as the register index
         if (req && hit && wb_we_i && (32'(pi) == i)) begin
            case (4'(wb_adr_i[3:2]) | {2'b00, 2'b00})
               default: ;
            endcase
         end
         if (req && (32'(pi) == i) && wb_we_i && wb_sel_i[0]) begin
            unique0 case (ri)
               gpb_pkg::REG_OUT: nxt_st.port[i].out =
                  wb_dat_i[7:0]; // R02
               gpb_pkg::REG_DM_LO: nxt_st.port[i].dm[11:0] =
                  wb_dat_i[11:0]; // R04
               gpb_pkg::REG_DM_HI: nxt_st.port[i].dm[23:12] =
                  wb_dat_i[11:0];
               gpb_pkg::REG_CFG: begin
                  nxt_st.port[i].slow = wb_dat_i[gpb_pkg::CFG_SLOW_LSB +: 8];
                  nxt_st.port[i].ttl = wb_dat_i[gpb_pkg::CFG_TTL_LSB +: 8];
               end
               gpb_pkg::REG_ROUTE: nxt_st.port[i].route = wb_dat_i[7:0];
               gpb_pkg::REG_HOLD: nxt_st.port[i].hold_en = wb_dat_i[7:0];
               gpb_pkg::REG_IRQ_CLR: clr = wb_dat_i[7:0];
               gpb_pkg::REG_IRQ_EN: nxt_st.port[i].en = wb_dat_i[7:0];
               gpb_pkg::REG_IRQ_EDGE: nxt_st.port[i].edge_sel =
                  wb_dat_i[7:0];
               default: ;
            endcase
         end
         // a new event wins over a clear in the same cycle
         nxt_st.port[i].stat = (st_ff.port[i].stat & ~clr) | evt; // R12
         nxt_st.irq[i] = |(nxt_st.port[i].stat & nxt_st.port[i].en); // R03

         // held pins keep their last pad state, deep sleep retention
         for (int b = 0; b < PW; b++) begin
            if (st_ff.held && st_ff.port[i].hold_en[b]) begin // R06
               nxt_st.pad[i].out[b] = st_ff.pad[i].out[b];
               nxt_st.pad[i].oe[b] = st_ff.pad[i].oe[b];
               nxt_st.pad[i].pull_up[b] = st_ff.pad[i].pull_up[b];
               nxt_st.pad[i].pull_dn[b] = st_ff.pad[i].pull_dn[b];
               nxt_st.pad[i].in_en[b] = st_ff.pad[i].in_en[b];
               nxt_st.pad[i].ttl[b] = st_ff.pad[i].ttl[b];
               nxt_st.pad[i].slow[b] = st_ff.pad[i].slow[b];
               nxt_st.pad[i].analog[b] = st_ff.pad[i].analog[b];
            end else begin
               nxt_st.pad[i].out[b] = pad_dec[i].out[b];
               nxt_st.pad[i].oe[b] = st_ff.port[i].route[b]
                  ? per_oe_pad[i*PW+b] & pad_dec[i].oe[b]
                  : pad_dec[i].oe[b];
               nxt_st.pad[i].pull_up[b] = pad_dec[i].pull_up[b];
               nxt_st.pad[i].pull_dn[b] = pad_dec[i].pull_dn[b];
               nxt_st.pad[i].in_en[b] = pad_dec[i].in_en[b];
               nxt_st.pad[i].ttl[b] = pad_dec[i].ttl[b];
               nxt_st.pad[i].slow[b] = pad_dec[i].slow[b];
               nxt_st.pad[i].analog[b] = pad_dec[i].analog[b];
            end
         end

         // reads; clear register is write-only and reads zero
         if (req && (32'(pi) == i)) begin
            case (ri)
               gpb_pkg::REG_OUT: nxt_st.rdata = {24'h000000,
                  st_ff.port[i].out};
               gpb_pkg::REG_IN: nxt_st.rdata = {24'h000000,
                  pin_sync[i*PW +: PW]}; // R02
               gpb_pkg::REG_DM_LO: nxt_st.rdata = {20'h00000,
                  st_ff.port[i].dm[11:0]};
               gpb_pkg::REG_DM_HI: nxt_st.rdata = {20'h00000,
                  st_ff.port[i].dm[23:12]};
               gpb_pkg::REG_CFG: nxt_st.rdata = {16'h0000,
                  st_ff.port[i].ttl, st_ff.port[i].slow};
               gpb_pkg::REG_ROUTE: nxt_st.rdata = {24'h000000,
                  st_ff.port[i].route};
               gpb_pkg::REG_HOLD: nxt_st.rdata = {24'h000000,
                  st_ff.port[i].hold_en};
               gpb_pkg::REG_IRQ_STAT: nxt_st.rdata = {24'h000000,
                  st_ff.port[i].stat};
               gpb_pkg::REG_IRQ_EN: nxt_st.rdata = {24'h000000,
                  st_ff.port[i].en};
               gpb_pkg::REG_IRQ_EDGE: nxt_st.rdata = {24'h000000,
                  st_ff.port[i].edge_sel};
               default: nxt_st.rdata = 32'h00000000;
            endcase
         end
      end
   end

   // reset puts every pad in analog mode with buffers off
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0; // R07
         for (int i = 0; i < NP; i++) begin
            st_ff.pad[i].analog <= 8'hFF; // R07
         end
      end else begin
         st_ff <= nxt_st;
      end
   end

   // flatten the registered pad bundles onto the 100 pins
   logic [PADDED-1:0] f_out, f_oe, f_pu, f_pd, f_ie, f_ttl, f_slow, f_an;
   generate
      for (p = 0; p < NP; p++) begin : g_flat
         assign f_out[p*PW +: PW] = st_ff.pad[p].out;
         assign f_oe[p*PW +: PW] = st_ff.pad[p].oe;
         assign f_pu[p*PW +: PW] = st_ff.pad[p].pull_up;
         assign f_pd[p*PW +: PW] = st_ff.pad[p].pull_dn;
         assign f_ie[p*PW +: PW] = st_ff.pad[p].in_en;
         assign f_ttl[p*PW +: PW] = st_ff.pad[p].ttl;
         assign f_slow[p*PW +: PW] = st_ff.pad[p].slow;
         assign f_an[p*PW +: PW] = st_ff.pad[p].analog;
      end
   endgenerate

   assign pin_o = f_out[gpb_pkg::NUM_PINS-1:0];
   assign pin_oe_o = f_oe[gpb_pkg::NUM_PINS-1:0];
   assign pull_up_o = f_pu[gpb_pkg::NUM_PINS-1:0];
   assign pull_dn_o = f_pd[gpb_pkg::NUM_PINS-1:0];
   assign in_en_o = f_ie[gpb_pkg::NUM_PINS-1:0];
   assign ttl_o = f_ttl[gpb_pkg::NUM_PINS-1:0];
   assign slow_o = f_slow[gpb_pkg::NUM_PINS-1:0];
   assign analog_o = f_an[gpb_pkg::NUM_PINS-1:0];
   // synchronised levels handed to peripherals directly, not gated by the routing matrix
   assign periph_in_o = pin_sync[gpb_pkg::NUM_PINS-1:0]; // R09
   assign port_irq_o = st_ff.irq; // R03
   assign wb_ack_o = st_ff.ack;
   assign wb_dat_o = st_ff.rdata;
endmodule // gpb_port_bank

// ==== src/gpb_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for a byte of pin levels
module gpb_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] d_i,
   output logic [7:0] q_o
);
   typedef struct packed {
      logic [7:0] s1;
      logic [7:0] s2;
   } gpb_sync_st_t;

   gpb_sync_st_t st_ff;
   gpb_sync_st_t nxt_st;

   // first stage feeds only the second
   always_comb begin
      nxt_st.s1 = d_i;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q_o = st_ff.s2;
endmodule // gpb_sync

// ==== test/gpb_pin_model.sv ====
`timescale 1ns/1ps
// far-side circuit: resolves each pad from drive, pulls and a source
module gpb_pin_model (
   input wire logic clk_i,
   input wire logic [gpb_pkg::NUM_PINS-1:0] pad_i,
   input wire logic [gpb_pkg::NUM_PINS-1:0] oe_i,
   input wire logic [gpb_pkg::NUM_PINS-1:0] pu_i,
   input wire logic [gpb_pkg::NUM_PINS-1:0] pd_i,
   input wire logic [gpb_pkg::NUM_PINS-1:0] ext_en_i,
   input wire logic [gpb_pkg::NUM_PINS-1:0] ext_lvl_i,
   output logic [gpb_pkg::NUM_PINS-1:0] lvl_o
);
   logic tgl_ff = 1'b0;
   // a floating pad reads as noise, never as a remembered level
   always @(posedge clk_i) tgl_ff <= ~tgl_ff;
   // device drive wins, then the outside source, then the pulls
   always_comb begin
      for (int i = 0; i < gpb_pkg::NUM_PINS; i++) begin
         if (oe_i[i]) lvl_o[i] = pad_i[i];
         else if (ext_en_i[i]) lvl_o[i] = ext_lvl_i[i];
         else if (pu_i[i]) lvl_o[i] = 1'b1;
         else if (pd_i[i]) lvl_o[i] = 1'b0;
         else lvl_o[i] = tgl_ff;
      end
   end
endmodule // gpb_pin_model

// ==== test/gpb_port_bank_properties.sv ====
`timescale 1ns/1ps
// watches the bank's pins and bus handshake from outside
module gpb_port_bank_properties (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [gpb_pkg::NUM_PINS-1:0] pin_i,
   input wire logic [gpb_pkg::NUM_PINS-1:0] pin_oe_o,
   input wire logic [gpb_pkg::NUM_PINS-1:0] in_en_o,
   input wire logic [gpb_pkg::NUM_PINS-1:0] analog_o,
   input wire logic [gpb_pkg::NUM_PINS-1:0] periph_in_o,
   input wire logic [gpb_pkg::NUM_PORTS-1:0] port_irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // reset checks must run while reset is high, so they opt out
   reset_pads_a: assert property (disable iff (1'b0)
      rst_i |=> (&analog_o) && pin_oe_o == '0 && in_en_o == '0)
      else $error("pads not parked in analog mode by reset");
   reset_irq_a: assert property (disable iff (1'b0)
      rst_i |=> port_irq_o == '0)
      else $error("port request not cleared by reset");
   ack_delay_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   ack_cause_a: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("acknowledge without a request");
   ack_idle_a: assert property (!wb_stb_i |=> !wb_ack_o)
      else $error("acknowledge while bus idle");
   analog_off_a: assert property (
      (analog_o & (pin_oe_o | in_en_o)) == '0)
      else $error("analog pin has a buffer enabled");
   sync_delay_a: assert property (
      !$past(rst_i) && !$past(rst_i, 2) |->
      periph_in_o == $past(pin_i, 2))
      else $error("pin level not two cycles behind the pad");
endmodule // gpb_port_bank_properties

// ==== test/tb_gpb_port_bank.sv ====
`timescale 1ns/1ps
module tb_gpb_port_bank;
   localparam int NP = gpb_pkg::NUM_PINS;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic [3:0] wb_sel_i = 4'hF;
   logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, hold_req_i = 1'b0;
   logic [NP-1:0] pin_i, periph_out_i = '0, periph_oe_i = '0;
   logic [NP-1:0] ext_en = '0, ext_lvl = '0;
   logic [NP-1:0] pin_o, pin_oe_o, pull_up_o, pull_dn_o, in_en_o;
   logic [NP-1:0] ttl_o, slow_o, analog_o, periph_in_o;
   logic [12:0] port_irq_o;
   logic [32:0] exp_q[$];
   logic [32:0] note;
   logic [15:0] rnd = 16'h9572;
   int failures = 0, comparisons = 0;
   always #50 clk_i = ~clk_i;
   gpb_port_bank gpb_port_bank_inst (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i,
      .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
      .pin_i, .periph_out_i, .periph_oe_i, .hold_req_i, .pin_o, .pin_oe_o,
      .pull_up_o, .pull_dn_o, .in_en_o, .ttl_o, .slow_o, .analog_o,
      .periph_in_o, .port_irq_o);
   gpb_pin_model gpb_pin_model_inst (.clk_i, .pad_i(pin_o), .oe_i(pin_oe_o),
      .pu_i(pull_up_o), .pd_i(pull_dn_o), .ext_en_i(ext_en),
      .ext_lvl_i(ext_lvl), .lvl_o(pin_i));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [7:0] ra(input logic [3:0] p, input logic [3:0] o);
      return {p, o};
   endfunction
   // one classic cycle; the note is queued before the request goes out
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d, input logic [32:0] nt);
      int n;
      exp_q.push_back(nt);
      @(posedge clk_i);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         failures++;
         close_out();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d, 33'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0, {1'b1, e});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // every acknowledge consumes the oldest note; reads are compared
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1) begin
         if (exp_q.size() == 0) check(32'h1, 32'h0);
         else begin
            note = exp_q.pop_front();
            if (note[32]) check(wb_dat_o, note[31:0]);
         end
      end
   end
   // main sequence
   initial begin
      tick(8);
      rst_i <= 1'b0;
      check(32'(&analog_o), 32'h1);
      rd(ra(4'h0, gpb_pkg::REG_OUT), 32'h0);
      rd(ra(4'hC, gpb_pkg::REG_DM_LO), 32'h0);
      wr(8'hD0, 32'hFF);
      rd(8'hD0, 32'h0);
      rd(ra(4'h0, 4'hB), 32'h0);
      wr(ra(4'hC, gpb_pkg::REG_DM_LO), 32'hDB6);
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         wr(ra(4'hC, gpb_pkg::REG_OUT), 32'(rnd[7:0]));
         rd(ra(4'hC, gpb_pkg::REG_OUT), 32'(rnd[7:0]));
      end
      tick(2);
      check(32'({pin_oe_o[99:96], pin_o[99:96]}), {24'h0, 4'hF, rnd[3:0]});
      // walk pin 0 of port 0 through every drive mode
      wr(ra(4'h0, gpb_pkg::REG_OUT), 32'h1);
      for (int m = 0; m < 8; m++) begin
         wr(ra(4'h0, gpb_pkg::REG_DM_LO), 32'(m));
         rd(ra(4'h0, gpb_pkg::REG_DM_LO), 32'(m));
         tick(2);
         check(32'(analog_o[0]), 32'(m == 0));
         if (m < 2) check(32'({pin_oe_o[0], in_en_o[0]}), 32'(m));
         if (m == 6) check(32'({pin_oe_o[0], pin_o[0]}), 32'h3);
         // weak-up or weak-down modes with data high pick one pull each
         if (m == 2) check(32'({pull_up_o[0], pull_dn_o[0]}), 32'h2);
         if (m == 3) check(32'({pull_up_o[0], pull_dn_o[0]}), 32'h1);
      end
      // port 1 as inputs fed from outside
      wr(ra(4'h1, gpb_pkg::REG_DM_LO), 32'h249);
      wr(ra(4'h1, gpb_pkg::REG_DM_HI), 32'h249);
      ext_en[15:8] <= 8'hFF;
      ext_lvl[15:8] <= rnd[15:8] & 8'hFE;
      tick(4);
      rd(ra(4'h1, gpb_pkg::REG_IN), 32'(rnd[15:8] & 8'hFE));
      // software slows the edges of a busy port group
      wr(ra(4'h1, gpb_pkg::REG_CFG), 32'h5AC3);
      tick(2);
      check(32'(slow_o[15:8]), 32'hC3);
      check(32'(ttl_o[15:8]), 32'h5A);
      // rising edge on pin 8, then mask, unmask, clear, falling edge
      wr(ra(4'h1, gpb_pkg::REG_IRQ_CLR), 32'hFF);
      wr(ra(4'h1, gpb_pkg::REG_IRQ_EN), 32'h1);
      ext_lvl[8] <= 1'b1;
      tick(6);
      check(32'(port_irq_o), 32'h2);
      rd(ra(4'h1, gpb_pkg::REG_IRQ_STAT), 32'h1);
      wr(ra(4'h1, gpb_pkg::REG_IRQ_EN), 32'h0);
      tick(2);
      check(32'(port_irq_o), 32'h0);
      rd(ra(4'h1, gpb_pkg::REG_IRQ_STAT), 32'h1);
      wr(ra(4'h1, gpb_pkg::REG_IRQ_EN), 32'h1);
      wr(ra(4'h1, gpb_pkg::REG_IRQ_CLR), 32'h1);
      tick(2);
      check(32'(port_irq_o), 32'h0);
      rd(ra(4'h1, gpb_pkg::REG_IRQ_STAT), 32'h0);
      wr(ra(4'h1, gpb_pkg::REG_IRQ_EDGE), 32'h1);
      ext_lvl[8] <= 1'b0;
      tick(6);
      check(32'(port_irq_o), 32'h2);
      // pin 0 handed to a peripheral whose data differs from the port
      wr(ra(4'h0, gpb_pkg::REG_DM_LO), 32'h6);
      periph_oe_i[0] <= 1'b1;
      wr(ra(4'h0, gpb_pkg::REG_ROUTE), 32'h1);
      tick(2);
      check(32'(pin_o[0]), 32'h0);
      periph_out_i[0] <= 1'b1;
      tick(3);
      check(32'(pin_o[0]), 32'h1);
      // pin 16 frozen by hold while its registers change
      wr(ra(4'h2, gpb_pkg::REG_DM_LO), 32'h6);
      wr(ra(4'h2, gpb_pkg::REG_OUT), 32'h1);
      wr(ra(4'h2, gpb_pkg::REG_HOLD), 32'h1);
      hold_req_i <= 1'b1;
      tick(2);
      wr(ra(4'h2, gpb_pkg::REG_OUT), 32'h0);
      wr(ra(4'h2, gpb_pkg::REG_DM_LO), 32'h0);
      tick(2);
      check(32'({analog_o[16], pin_o[16]}), 32'h1);
      hold_req_i <= 1'b0;
      tick(3);
      check(32'(analog_o[16]), 32'h1);
      // second reset with a request pending
      rst_i <= 1'b1;
      tick(2);
      rst_i <= 1'b0;
      check(32'(port_irq_o), 32'h0);
      check(32'(&analog_o), 32'h1);
      rd(ra(4'h1, gpb_pkg::REG_IRQ_EN), 32'h0);
      tick(2);
      close_out();
   end
endmodule // tb_gpb_port_bank
bind gpb_port_bank gpb_port_bank_properties gpb_port_bank_properties_inst (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pin_i, .pin_oe_o,
   .in_en_o, .analog_o, .periph_in_o, .port_irq_o);
